// *** include/pinmux_pkg.sv ***
// constants shared by the transceiver pin end and the mac pin end
package pinmux_pkg;
	typedef enum logic [1:0] {
		MODE_MII = 2'b00,
		MODE_RMII = 2'b01,
		MODE_SMII = 2'b10,
		MODE_B2B = 2'b11
	} mode_t;
	// clock rates in mhz and derived half periods in aclk cycles
	localparam int CLK_MHZ = 100;
	localparam int REF_MII_MHZ = 25;
	localparam int REF_RMII_MHZ = 50;
	localparam int REF_SMII_MHZ = 125;
	localparam int HALF_MII = CLK_MHZ / (2 * REF_MII_MHZ);
	localparam int HALF_RMII = CLK_MHZ / (2 * REF_RMII_MHZ);
	localparam int HALF_SMII = 1;
	localparam int MDC_HALF = 8;
	localparam int SYNC_PERIOD = 10;
	localparam logic [2:0] STRAP_WAIT = 3'h4;
	// strap to mode decode
	localparam logic [2:0] CFG_RMII = 3'h1;
	localparam logic [2:0] CFG_SMII = 3'h2;
	localparam logic [2:0] CFG_B2B = 3'h4;
	// strap vector positions
	localparam int SP_VALID = 4;
	localparam int SP_ERROR = 5;
	localparam int SP_COL = 6;
	localparam int SP_CRS = 7;
	localparam int SP_LED0 = 8;
	// management registers and bits
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_INT = 5'h1b;
	localparam logic [4:0] REG_PHYCTL = 5'h1f;
	localparam int DUPLEX_BIT = 8;
	localparam int ISO_BIT = 10;
	localparam int ANEG_BIT = 12;
	localparam int IRQ_POL_BIT = 9;
	localparam logic [1:0] OP_WR = 2'h1;
	localparam logic [1:0] OP_RD = 2'h2;
	localparam logic [1:0] TA_WR = 2'h2;
	localparam logic [31:0] PREAMBLE = 32'hffffffff;
	localparam logic [1:0] START = 2'h1;
	localparam logic [5:0] HDR_BITS = 6'h2e;
	localparam logic [5:0] DATA_FIRST = 6'h30;
	// mac side axi register offsets
	localparam logic [4:0] A_CTRL = 5'h00;
	localparam logic [4:0] A_MDIO = 5'h04;
	localparam logic [4:0] A_STAT = 5'h08;
	localparam logic [4:0] A_STRAP = 5'h0c;
	localparam logic [4:0] A_PINS = 5'h10;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// *** include/phy_mac_if.sv ***
// pins between the transceiver and the mac, with strap pulls and wire resolution
`timescale 1ns/1ps
interface phy_mac_if;
	// device driven pins
	logic [3:0] rxd_d, rxd_oe;
	logic rv_d, rv_oe, er_d, er_oe, col_d, crs_d, cc_oe, led0_d, led0_oe;
	logic xfb_d, xfb_oe, rx_clock_pin, irq_out, dev_txc_d, dev_txc_oe, dev_mdio_d, dev_mdio_oe;
	// mac driven pins and strap pull levels
	logic [8:0] pull;
	logic [3:0] txd;
	logic ref_clock_in, tx_enable_pin, mdc, mac_txc_d, mac_txc_oe, mac_mdio_d, mac_mdio_oe;
	// resolved wire levels
	logic [3:0] rxd;
	logic rx_valid_pin, rx_error_pin, col, crs, led0, tx_clock_pin, mdio;
	for (genvar i = 0; i < 4; i++)
	begin : g_rxd
		assign rxd[i] = rxd_oe[i] ? rxd_d[i] : pull[i];
	end
	assign rx_valid_pin = rv_oe ? rv_d : pull[4];
	assign rx_error_pin = er_oe ? er_d : pull[5];
	assign col = cc_oe ? col_d : pull[6];
	assign crs = cc_oe ? crs_d : pull[7];
	assign led0 = led0_oe ? led0_d : pull[8];
	assign tx_clock_pin = dev_txc_oe ? dev_txc_d : (mac_txc_oe & mac_txc_d);
	assign mdio = (~dev_mdio_oe | dev_mdio_d) & (~mac_mdio_oe | mac_mdio_d);
	modport dev (
		output rxd_d, rxd_oe, rv_d, rv_oe, er_d, er_oe, col_d, crs_d, cc_oe, led0_d, led0_oe,
		output xfb_d, xfb_oe, rx_clock_pin, irq_out, dev_txc_d, dev_txc_oe, dev_mdio_d, dev_mdio_oe,
		input rxd, rx_valid_pin, rx_error_pin, col, crs, led0, tx_clock_pin, mdio,
		input txd, ref_clock_in, tx_enable_pin, mdc
	);
	modport mac (
		output pull, txd, ref_clock_in, tx_enable_pin, mdc, mac_txc_d, mac_txc_oe,
		output mac_mdio_d, mac_mdio_oe,
		input rxd, rx_valid_pin, rx_error_pin, col, crs, led0, tx_clock_pin, mdio,
		input rx_clock_pin, irq_out
	);
endinterface

// *** design/pin_sync.sv ***
// two flip-flop synchroniser per bit for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pins and synchronised levels
	input wire logic [W-1:0] pin,
	output logic [W-1:0] sync
);
	logic [W-1:0] meta_r;
	for (genvar i = 0; i < W; i++)
	begin : g_bit
		// first stage feeds only the second
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				meta_r[i] <= 1'b0;
				sync[i] <= 1'b0;
			end
			else
			begin
				meta_r[i] <= pin[i];
				sync[i] <= meta_r[i];
			end
		end
	end
endmodule // pin_sync

// *** design/phy_pin_end.sv ***
// transceiver end: pin function per mode, power-up straps, management registers
//
// Behaviour
// - mac supplies 25 mhz reference in mii, 50 mhz in the other modes
// - crystal feedback driven only for mii crystal
// - rx data 3,2,1 strap address bits 0,1,2
// - rx data 0 strap sets duplex bit
// - interrupt active low unless polarity bit set
// - register 1bh enables and reports interrupts
// - tx clock output in mii, input back-to-back
// - management bits move on station clock
// - rmii: carrier and valid combined on valid pin
// - smii serial data on data pin 0
// - smii sync arrives on tx data pin 1
// - mac sends four or two tx bits
// - four rx bits in mii, two in rmii
// - rx error driven in mii and rmii
// - mac drives tx enable in mii, rmii
// - rx clock driven in mii
// - col, crs strap config 0,1 then outputs in mii and back-to-back
// - led0 strap autoneg, fiber forces it off
`timescale 1ns/1ps
module phy_pin_end (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pins toward the mac
	phy_mac_if.dev pins,
	// receive side from the line core
	input wire logic [3:0] rx_data,
	input wire logic rx_dv,
	input wire logic rx_er,
	input wire logic rx_col,
	input wire logic rx_crs,
	input wire logic rx_serial,
	input wire logic link_up,
	input wire logic [7:0] events,
	// board options
	input wire logic xtal_used,
	input wire logic fiber_mode_select,
	// transmit side to the line core
	output logic [3:0] tx_data_r,
	output logic tx_en_r,
	output logic tx_serial_r,
	output logic smii_sync_r,
	output logic tx_clk_seen_r,
	// latched configuration
	output logic [2:0] phy_address_strap_r,
	output pinmux_pkg::mode_t mode_r,
	output logic strap_done_r
);
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_START = 3'b001,
		M_HDR = 3'b010,
		M_TA = 3'b011,
		M_DATA = 3'b100
	} mstate_t;
	mstate_t mst_r;
	logic [17:0] s;
	logic [8:0] strap;
	logic [2:0] wait_r, cfg;
	logic mdc_prev_r, mdc_rise, bit_in, rd_sel_r, wr_sel_r, iso;
	logic [11:0] hdr_r, hdr_nxt;
	logic [3:0] cnt_r;
	logic [15:0] sh_r, ctrl_r, rdata, wdata_nxt;
	logic [7:0] int_en_r, pend_r, pend_clr;
	logic pol_r, wr_fire, clr_fire;
	logic [1:0] rxc_cnt_r;
	logic rxc_r;

	// every pin from the mac side passes the synchroniser
	pin_sync #(.W(18)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin({pins.ref_clock_in, pins.mdc, pins.mdio, pins.tx_clock_pin, pins.tx_enable_pin,
			pins.txd, pins.led0, pins.crs, pins.col, pins.rx_error_pin, pins.rx_valid_pin,
			pins.rxd}),
		.sync(s)
	);
	assign strap = s[8:0];
	assign cfg = {strap[pinmux_pkg::SP_VALID], strap[pinmux_pkg::SP_CRS],
		strap[pinmux_pkg::SP_COL]};
	assign iso = ctrl_r[pinmux_pkg::ISO_BIT];

	// strap sampling once the synchroniser has settled after reset release
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wait_r <= 3'h0;
			strap_done_r <= 1'b0;
			phy_address_strap_r <= 3'h0;
			mode_r <= pinmux_pkg::MODE_MII;
		end
		else if (!strap_done_r)
		begin
			wait_r <= wait_r + 3'h1;
			if (wait_r == pinmux_pkg::STRAP_WAIT)
			begin
				strap_done_r <= 1'b1;
				phy_address_strap_r <= {strap[1], strap[2], strap[3]};
				if (cfg == pinmux_pkg::CFG_RMII)
					mode_r <= pinmux_pkg::MODE_RMII;
				else if (cfg == pinmux_pkg::CFG_SMII)
					mode_r <= pinmux_pkg::MODE_SMII;
				else if (cfg == pinmux_pkg::CFG_B2B)
					mode_r <= pinmux_pkg::MODE_B2B;
				else
					mode_r <= pinmux_pkg::MODE_MII;
			end
		end
	end

	// management clock edge and sampled data bit
	assign mdc_rise = s[16] & ~mdc_prev_r;
	assign bit_in = s[15];
	assign hdr_nxt = {hdr_r[10:0], bit_in};
	assign wdata_nxt = {sh_r[14:0], bit_in};
	assign wr_fire = mdc_rise && mst_r == M_DATA && cnt_r == 4'hf && wr_sel_r;
	assign clr_fire = mdc_rise && mst_r == M_TA && cnt_r == 4'h1 && rd_sel_r
		&& hdr_r[4:0] == pinmux_pkg::REG_INT;

	// register read mux
	always_comb
	begin
		rdata = 16'h0000;
		if (hdr_r[4:0] == pinmux_pkg::REG_CTRL)
			rdata = ctrl_r;
		else if (hdr_r[4:0] == pinmux_pkg::REG_INT)
			rdata = {int_en_r, pend_r};
		else if (hdr_r[4:0] == pinmux_pkg::REG_PHYCTL)
			rdata = 16'(pol_r) << pinmux_pkg::IRQ_POL_BIT;
	end

	// management frame receiver and read data driver
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mdc_prev_r <= 1'b0;
			mst_r <= M_IDLE;
			hdr_r <= 12'h000;
			cnt_r <= 4'h0;
			sh_r <= 16'h0000;
			rd_sel_r <= 1'b0;
			wr_sel_r <= 1'b0;
			pins.dev_mdio_d <= 1'b0;
			pins.dev_mdio_oe <= 1'b0;
		end
		else
		begin
			mdc_prev_r <= s[16];
			if (mdc_rise)
			begin
				case (mst_r)
					M_IDLE:
						if (!bit_in && strap_done_r)
							mst_r <= M_START;
					M_START:
					begin
						mst_r <= bit_in ? M_HDR : M_IDLE;
						cnt_r <= 4'h0;
					end
					M_HDR:
					begin
						hdr_r <= hdr_nxt;
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == 4'hb)
						begin
							mst_r <= M_TA;
							cnt_r <= 4'h0;
							rd_sel_r <= hdr_nxt[11:10] == pinmux_pkg::OP_RD
								&& hdr_nxt[9:5] == {2'b00, phy_address_strap_r};
							wr_sel_r <= hdr_nxt[11:10] == pinmux_pkg::OP_WR
								&& hdr_nxt[9:5] == {2'b00, phy_address_strap_r};
						end
					end
					M_TA:
					begin
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == 4'h0)
						begin
							pins.dev_mdio_oe <= rd_sel_r;
							pins.dev_mdio_d <= 1'b0;
						end
						else
						begin
							mst_r <= M_DATA;
							cnt_r <= 4'h0;
							pins.dev_mdio_d <= rdata[15];
							sh_r <= {rdata[14:0], 1'b0};
						end
					end
					M_DATA:
					begin
						cnt_r <= cnt_r + 4'h1;
						if (rd_sel_r)
						begin
							pins.dev_mdio_d <= sh_r[15];
							sh_r <= {sh_r[14:0], 1'b0};
						end
						else
							sh_r <= wdata_nxt;
						if (cnt_r == 4'hf)
						begin
							mst_r <= M_IDLE;
							pins.dev_mdio_oe <= 1'b0;
							pins.dev_mdio_d <= 1'b0;
						end
					end
					default:
						mst_r <= M_IDLE;
				endcase
			end
		end
	end

	// control register: strap defaults, then management writes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_r <= 16'h0000;
		else if (!strap_done_r && wait_r == pinmux_pkg::STRAP_WAIT)
		begin
			ctrl_r <= 16'h0000;
			ctrl_r[pinmux_pkg::DUPLEX_BIT] <= strap[0];
			ctrl_r[pinmux_pkg::ISO_BIT] <= strap[pinmux_pkg::SP_ERROR];
			ctrl_r[pinmux_pkg::ANEG_BIT] <= strap[pinmux_pkg::SP_LED0]
				& ~fiber_mode_select;
		end
		else if (wr_fire && hdr_r[4:0] == pinmux_pkg::REG_CTRL)
			ctrl_r <= wdata_nxt;
	end

	// interrupt enables, sticky pending with set over read clear, polarity
	assign pend_clr = clr_fire ? 8'hff : 8'h00;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			int_en_r <= 8'h00;
			pend_r <= 8'h00;
			pol_r <= 1'b0;
			pins.irq_out <= 1'b1;
		end
		else
		begin
			pend_r <= (pend_r & ~pend_clr) | events;
			if (wr_fire && hdr_r[4:0] == pinmux_pkg::REG_INT)
				int_en_r <= wdata_nxt[15:8];
			if (wr_fire && hdr_r[4:0] == pinmux_pkg::REG_PHYCTL)
				pol_r <= wdata_nxt[pinmux_pkg::IRQ_POL_BIT];
			pins.irq_out <= (|(pend_r & int_en_r)) ~^ pol_r;
		end
	end

	// receive pin functions per mode, all released until straps are taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !strap_done_r || iso)
		begin
			pins.rxd_d <= 4'h0;
			pins.rxd_oe <= 4'h0;
			pins.rv_d <= 1'b0;
			pins.rv_oe <= 1'b0;
			pins.er_d <= 1'b0;
			pins.er_oe <= 1'b0;
			pins.col_d <= 1'b0;
			pins.crs_d <= 1'b0;
			pins.cc_oe <= 1'b0;
			pins.led0_d <= 1'b0;
			pins.led0_oe <= 1'b0;
		end
		else
		begin
			pins.led0_d <= ~link_up;
			pins.led0_oe <= 1'b1;
			pins.er_d <= rx_er;
			pins.col_d <= rx_col;
			pins.crs_d <= rx_crs;
			case (mode_r)
				pinmux_pkg::MODE_RMII:
				begin
					pins.rxd_d <= {2'b00, rx_data[1:0]};
					pins.rxd_oe <= 4'h3;
					pins.rv_d <= rx_crs | rx_dv;
					pins.rv_oe <= 1'b1;
					pins.er_oe <= 1'b1;
					pins.cc_oe <= 1'b0;
				end
				pinmux_pkg::MODE_SMII:
				begin
					pins.rxd_d <= {3'b000, rx_serial};
					pins.rxd_oe <= 4'h1;
					pins.rv_d <= 1'b0;
					pins.rv_oe <= 1'b0;
					pins.er_oe <= 1'b0;
					pins.cc_oe <= 1'b0;
				end
				default:
				begin
					pins.rxd_d <= rx_data;
					pins.rxd_oe <= 4'hf;
					pins.rv_d <= rx_dv;
					pins.rv_oe <= 1'b1;
					pins.er_oe <= 1'b1;
					pins.cc_oe <= 1'b1;
				end
			endcase
		end
	end

	// receive and transmit clocks, crystal feedback
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rxc_cnt_r <= 2'h0;
			rxc_r <= 1'b0;
			pins.rx_clock_pin <= 1'b0;
			pins.dev_txc_d <= 1'b0;
			pins.dev_txc_oe <= 1'b0;
			pins.xfb_d <= 1'b0;
			pins.xfb_oe <= 1'b0;
		end
		else
		begin
			rxc_cnt_r <= rxc_cnt_r + 2'h1;
			if (rxc_cnt_r == 2'(pinmux_pkg::HALF_MII - 1))
			begin
				rxc_cnt_r <= 2'h0;
				rxc_r <= ~rxc_r;
			end
			pins.rx_clock_pin <= rxc_r & (mode_r == pinmux_pkg::MODE_MII);
			pins.dev_txc_d <= rxc_r;
			pins.dev_txc_oe <= mode_r == pinmux_pkg::MODE_MII;
			pins.xfb_oe <= mode_r == pinmux_pkg::MODE_MII && xtal_used;
			pins.xfb_d <= ~s[17] & (mode_r == pinmux_pkg::MODE_MII) & xtal_used;
		end
	end

	// transmit pins into the line core, width per mode
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_data_r <= 4'h0;
			tx_en_r <= 1'b0;
			tx_serial_r <= 1'b0;
			smii_sync_r <= 1'b0;
			tx_clk_seen_r <= 1'b0;
		end
		else
		begin
			tx_en_r <= s[13] && mode_r != pinmux_pkg::MODE_SMII;
			tx_data_r <= mode_r == pinmux_pkg::MODE_RMII ? {2'b00, s[10:9]}
				: s[12:9];
			tx_serial_r <= s[9] & (mode_r == pinmux_pkg::MODE_SMII);
			smii_sync_r <= s[10] & (mode_r == pinmux_pkg::MODE_SMII);
			tx_clk_seen_r <= s[14] & (mode_r == pinmux_pkg::MODE_B2B);
		end
	end
endmodule // phy_pin_end

// *** design/mac_pin_end.sv ***
// mac end: axi4-lite registers, reference clock, straps, transmit pins, mdio master
`timescale 1ns/1ps
module mac_pin_end (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [4:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [4:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// pins toward the transceiver
	phy_mac_if.mac pins
);
	logic [4:0] wa_r;
	logic [31:0] wd_r, rd_nxt;
	logic [2:0] ctrl_r;
	logic [63:0] msh_r;
	logic [5:0] mcnt_r;
	logic [3:0] mdiv_r, sync_cnt_r;
	logic [15:0] mrd_r;
	logic busy_r, mrd_op_r, ref_cnt_r, wr_fire;
	logic [1:0] ref_half;
	logic [10:0] s;
	pinmux_pkg::mode_t mode;

	// device pins pass the synchroniser before any read
	pin_sync #(.W(11)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin({pins.mdio, pins.irq_out, pins.rx_clock_pin, pins.crs, pins.col,
			pins.rx_error_pin, pins.rx_valid_pin, pins.rxd}),
		.sync(s)
	);
	assign mode = pinmux_pkg::mode_t'(ctrl_r[1:0]);
	assign wr_fire = !awready && !wready && !bvalid;

	// axi write channels taken in any order, response after both
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= pinmux_pkg::RESP_OK;
			wa_r <= 5'h00;
			wd_r <= 32'h00000000;
		end
		else
		begin
			if (awvalid && awready)
			begin
				wa_r <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready)
			begin
				wd_r <= wdata;
				wready <= 1'b0;
			end
			if (wr_fire)
			begin
				bvalid <= 1'b1;
				bresp <= wa_r > pinmux_pkg::A_PINS || wa_r[1:0] != 2'b00
					? pinmux_pkg::RESP_ERR : pinmux_pkg::RESP_OK;
			end
			if (bvalid && bready)
			begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// read mux
	always_comb
	begin
		rd_nxt = 32'h00000000;
		if (araddr == pinmux_pkg::A_CTRL)
			rd_nxt = {29'h0, ctrl_r};
		else if (araddr == pinmux_pkg::A_STAT)
			rd_nxt = {15'h0, busy_r, mrd_r};
		else if (araddr == pinmux_pkg::A_STRAP)
			rd_nxt = {23'h0, pins.pull};
		else if (araddr == pinmux_pkg::A_PINS)
			rd_nxt = {16'h0, pins.tx_enable_pin, pins.txd, 1'b0, s[9:0]};
	end

	// axi read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= pinmux_pkg::RESP_OK;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_nxt;
			rresp <= araddr > pinmux_pkg::A_PINS || araddr[1:0] != 2'b00
				|| araddr == pinmux_pkg::A_MDIO ? pinmux_pkg::RESP_ERR : pinmux_pkg::RESP_OK;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// software registers: mode, straps, transmit pins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= 3'h0;
			pins.pull <= 9'h000;
			pins.txd <= 4'h0;
			pins.tx_enable_pin <= 1'b0;
			sync_cnt_r <= 4'h0;
		end
		else
		begin
			sync_cnt_r <= sync_cnt_r == 4'(pinmux_pkg::SYNC_PERIOD - 1) ? 4'h0 : sync_cnt_r + 4'h1;
			if (wr_fire && wa_r == pinmux_pkg::A_CTRL && wstrb[0])
				ctrl_r <= wd_r[2:0];
			if (wr_fire && wa_r == pinmux_pkg::A_STRAP)
				pins.pull <= wd_r[8:0];
			if (wr_fire && wa_r == pinmux_pkg::A_PINS)
			begin
				pins.txd[0] <= wd_r[0];
				pins.txd[1] <= wd_r[1];
				pins.txd[3:2] <= mode == pinmux_pkg::MODE_MII ? wd_r[3:2] : 2'b00;
				pins.tx_enable_pin <= wd_r[4] && mode != pinmux_pkg::MODE_SMII;
			end
			// sync pulse replaces the written level only in smii
			if (mode == pinmux_pkg::MODE_SMII)
				pins.txd[1] <= sync_cnt_r == 4'h0;
		end
	end

	// reference clock by divider, and tx clock in back-to-back
	assign ref_half = mode == pinmux_pkg::MODE_MII ? 2'(pinmux_pkg::HALF_MII)
		: mode == pinmux_pkg::MODE_RMII ? 2'(pinmux_pkg::HALF_RMII) : 2'(pinmux_pkg::HALF_SMII);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ref_cnt_r <= 1'b0;
			pins.ref_clock_in <= 1'b0;
			pins.mac_txc_d <= 1'b0;
			pins.mac_txc_oe <= 1'b0;
		end
		else
		begin
			ref_cnt_r <= ~ref_cnt_r;
			if (ref_half == 2'h1 || ref_cnt_r)
				pins.ref_clock_in <= ~pins.ref_clock_in;
			pins.mac_txc_d <= pins.ref_clock_in;
			pins.mac_txc_oe <= mode == pinmux_pkg::MODE_B2B;
		end
	end

	// mdio master: bits change on mdc fall, sampled on mdc rise
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			busy_r <= 1'b0;
			mrd_op_r <= 1'b0;
			msh_r <= 64'h0;
			mcnt_r <= 6'h00;
			mdiv_r <= 4'h0;
			mrd_r <= 16'h0000;
			pins.mdc <= 1'b0;
			pins.mac_mdio_d <= 1'b0;
			pins.mac_mdio_oe <= 1'b0;
		end
		else if (!busy_r)
		begin
			if (wr_fire && wa_r == pinmux_pkg::A_MDIO)
			begin
				busy_r <= 1'b1;
				mrd_op_r <= wd_r[17:16] == pinmux_pkg::OP_RD;
				// command: [27:23] phy, [22:18] register, [17:16] op, [15:0] data
				msh_r <= {pinmux_pkg::PREAMBLE, pinmux_pkg::START, wd_r[17:16], wd_r[27:23],
					wd_r[22:18], pinmux_pkg::TA_WR, wd_r[15:0]} << 1;
				pins.mac_mdio_d <= 1'b1;
				pins.mac_mdio_oe <= 1'b1;
				mcnt_r <= 6'h00;
				mdiv_r <= 4'h0;
			end
		end
		else
		begin
			mdiv_r <= mdiv_r + 4'h1;
			if (mdiv_r == 4'(pinmux_pkg::MDC_HALF - 1))
			begin
				mdiv_r <= 4'h0;
				pins.mdc <= ~pins.mdc;
				if (!pins.mdc)
				begin
					mcnt_r <= mcnt_r + 6'h1;
					if (mcnt_r >= pinmux_pkg::DATA_FIRST && mrd_op_r)
						mrd_r <= {mrd_r[14:0], s[10]};
				end
				else
				begin
					pins.mac_mdio_d <= msh_r[63];
					msh_r <= {msh_r[62:0], 1'b0};
					pins.mac_mdio_oe <= !mrd_op_r || mcnt_r < pinmux_pkg::HDR_BITS;
					// count wrapped after the 64th rise: ending on this fall leaves mdc low
					// and keeps the last bit standing while the far end samples it
					if (mcnt_r == 6'h00)
					begin
						busy_r <= 1'b0;
						pins.mac_mdio_oe <= 1'b0;
					end
				end
			end
		end
	end
endmodule // mac_pin_end

// *** test/pin_assertions.sv ***
// checker watching the pins between the two ends
`timescale 1ns/1ps
module pin_assertions (
	// clock and device reset
	input wire logic aclk,
	input wire logic aresetn,
	// pin levels and enables
	input wire logic [8:0] pull,
	input wire logic [3:0] rxd_oe,
	input wire logic rv_oe,
	input wire logic cc_oe,
	input wire logic xfb_oe,
	input wire logic dev_txc_oe,
	input wire logic rx_clock_pin,
	input wire logic irq_out
);
	logic [2:0] cnt_r;
	logic [8:0] sp_r;
	logic [1:0] md;
	logic on;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// edges since release, saturating
	always_ff @(posedge aclk)
		if (!aresetn)
			cnt_r <= 3'h0;
		else if (cnt_r != 3'h7)
			cnt_r <= cnt_r + 3'h1;
	// own copy of the strap levels
	always_ff @(posedge aclk)
		if (cnt_r == 3'h6)
			sp_r <= pull;
	// mode from {valid, crs, col} straps
	always_comb
		case ({sp_r[4], sp_r[7], sp_r[6]})
			3'h1: md = 2'h1;
			3'h2: md = 2'h2;
			3'h4: md = 2'h3;
			default: md = 2'h0;
		endcase
	assign on = cnt_r == 3'h7 && !sp_r[5];
	sequence s_rxclk_fall;
		##[1:4] $fell(rx_clock_pin);
	endsequence
	chk_reset_quiet: assert property (disable iff (1'b0)
		!aresetn |=> rxd_oe == 4'h0 && !rv_oe && irq_out)
		else $error("pins driven or irq active after reset");
	chk_strap_wait: assert property (cnt_r < 3'h6 |-> rxd_oe == 4'h0 && !cc_oe)
		else $error("pins driven during strap wait");
	chk_mii_width: assert property (on && md == 2'h0 |-> rxd_oe == 4'hf && cc_oe)
		else $error("mii pins not all driven");
	chk_rmii_width: assert property (on && md == 2'h1 |-> rxd_oe == 4'h3 && rv_oe)
		else $error("rmii pin set wrong");
	chk_smii_lane: assert property (on && md == 2'h2 |-> rxd_oe[0])
		else $error("smii lane not driven");
	chk_isolate: assert property (cnt_r == 3'h7 && sp_r[5] |-> rxd_oe == 4'h0 && !rv_oe)
		else $error("isolate left pins driven");
	chk_txc_dir: assert property (on && md[0] == md[1] |-> dev_txc_oe == !md[0])
		else $error("tx clock direction wrong");
	chk_xfb_off: assert property (cnt_r == 3'h7 && md != 2'h0 |-> !xfb_oe)
		else $error("crystal feedback driven outside mii");
	chk_rxclk_run: assert property (on && md == 2'h0 && $rose(rx_clock_pin) |-> s_rxclk_fall)
		else $error("rx clock stuck high");
endmodule // pin_assertions

// *** test/tb.sv ***
// bench for the two pin ends joined by the pin interface
`timescale 1ns/1ps
module tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic phy_rstn = 1'b0;
	logic [4:0] awaddr = 5'h0, araddr = 5'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic awready, wready, bvalid, arready, rvalid, tx_en_r, tx_serial_r, smii_sync_r;
	logic tx_clk_seen_r, strap_done_r, t, seen;
	logic [1:0] bresp, rresp, r;
	logic [3:0] rx_data = 4'h9, tx_data_r;
	logic rx_dv = 1'b0, rx_er = 1'b1, rx_col = 1'b1, rx_crs = 1'b1, rx_serial = 1'b1, fiber = 1'b0;
	logic [7:0] events = 8'h0;
	logic [2:0] phy_address_strap_r, ea;
	pinmux_pkg::mode_t mode_r;
	logic [8:0] pv [5] = '{9'h10d, 9'h04c, 9'h082, 9'h01a, 9'h125};
	logic [1:0] mt [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
	int fails = 0, checks_done = 0, cyc = 0;
	phy_mac_if link ();
	mac_pin_end i_mac_pin_end (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .pins(link));
	phy_pin_end i_phy_pin_end (.aclk, .aresetn(phy_rstn), .pins(link), .rx_data, .rx_dv,
		.rx_er, .rx_col, .rx_crs, .rx_serial, .link_up(1'b1), .events, .xtal_used(1'b1),
		.fiber_mode_select(fiber), .tx_data_r, .tx_en_r, .tx_serial_r, .smii_sync_r,
		.tx_clk_seen_r, .phy_address_strap_r, .mode_r, .strap_done_r);
	pin_assertions i_chk (.aclk, .aresetn(phy_rstn), .pull(link.pull), .rxd_oe(link.rxd_oe),
		.rv_oe(link.rv_oe), .cc_oe(link.cc_oe), .xfb_oe(link.xfb_oe),
		.dev_txc_oe(link.dev_txc_oe), .rx_clock_pin(link.rx_clock_pin), .irq_out(link.irq_out));
	always #5 aclk = ~aclk;
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask
	// axi write, address and data offered together
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata;
		e = rresp;
		rready <= 1'b0;
	endtask
	// management frame through the mac, then wait until it is idle again
	task automatic mdio(input logic [31:0] c);
		wr(pinmux_pkg::A_MDIO, c);
		repeat (4) @(posedge aclk);
		do
			rd(pinmux_pkg::A_STAT, v, r);
		while (v[16] !== 1'b0);
	endtask
	// cycle ceiling against hangs
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails++;
			summarize();
		end
	end
	// one pass per strap set
	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(5'h14, v, r);
		cmp("unmapped resp", {30'h0, pinmux_pkg::RESP_ERR}, {30'h0, r});
		for (int p = 0; p < 5; p++)
		begin
			phy_rstn <= 1'b0;
			fiber <= p == 4;
			ea = {pv[p][1], pv[p][2], pv[p][3]};
			wr(pinmux_pkg::A_STRAP, {23'h0, pv[p]});
			wr(pinmux_pkg::A_CTRL, {30'h0, mt[p]});
			phy_rstn <= 1'b1;
			repeat (12) @(posedge aclk);
			cmp("mode", {30'h0, mt[p]}, {30'h0, mode_r});
			cmp("address", {29'h0, ea}, {29'h0, phy_address_strap_r});
			mdio({6'h0, ea, pinmux_pkg::REG_CTRL, pinmux_pkg::OP_RD, 16'h0});
			cmp("ctrl", {29'h0, pv[p][8] & ~fiber, pv[p][5], pv[p][0]},
				{29'h0, v[12], v[10], v[8]});
			if (p == 0)
			begin
				cmp("rx data", {28'h0, rx_data}, {28'h0, link.rxd});
				cmp("crs col er", 32'h7, {29'h0, link.crs, link.col, link.rx_error_pin});
				cmp("xtal fb", 32'h1, {31'h0, link.xfb_oe});
				wr(pinmux_pkg::A_PINS, 32'h0000001a);
				repeat (8) @(posedge aclk);
				cmp("tx pins", 32'h1a, {27'h0, tx_en_r, tx_data_r});
				mdio({6'h0, ea, pinmux_pkg::REG_INT, pinmux_pkg::OP_WR, 16'h0100});
				events <= 8'h01;
				@(posedge aclk);
				events <= 8'h00;
				repeat (4) @(posedge aclk);
				cmp("irq low", 32'h0, {31'h0, link.irq_out});
				mdio({6'h0, ea, pinmux_pkg::REG_INT, pinmux_pkg::OP_RD, 16'h0});
				cmp("int reg", 32'h0101, {16'h0, v[15:0]});
				cmp("irq idle", 32'h1, {31'h0, link.irq_out});
				mdio({6'h0, ea, pinmux_pkg::REG_PHYCTL, pinmux_pkg::OP_WR, 16'h0200});
				cmp("irq polarity", 32'h0, {31'h0, link.irq_out});
			end
			if (p == 1)
				cmp("rmii", {29'h0, rx_crs | rx_dv, rx_data[1:0]},
					{29'h0, link.rx_valid_pin, link.rxd[1:0]});
			if (p == 2)
			begin
				cmp("smii rx", {31'h0, rx_serial}, {31'h0, link.rxd[0]});
				for (int i = 0; i < 30 && smii_sync_r !== 1'b1; i++)
					@(posedge aclk);
				cmp("sync", 32'h1, {31'h0, smii_sync_r});
			end
			if (p == 3)
			begin
				t = tx_clk_seen_r;
				seen = 1'b0;
				repeat (40)
				begin
					@(posedge aclk);
					seen = seen | (tx_clk_seen_r !== t);
				end
				cmp("tx clock in", 32'h1, {31'h0, seen});
			end
			if (p == 4)
				cmp("isolated", 32'h0, {28'h0, link.rxd_oe});
			$display("test %0d done", p);
		end
		summarize();
	end
endmodule // tb
